// ---- design/sx_defs.svh ----
// Constants for the swap, skip, table read and XOR execution unit.
`ifndef SX_DEFS_SVH
`define SX_DEFS_SVH

// Data widths.
`define SX_DW          8
`define SX_MEM_AW      7
`define SX_ROM_AW      10
`define SX_ROM_DW      14
`define SX_PAGE_W      2
`define SX_HIGH_W      6
`define SX_LAST_PAGE   2'h3
`define SX_ZERO_BYTE   8'h00

// Instruction codes on the decode port.
`define SX_OP_W        4
`define SX_OP_SWAP     4'h0
`define SX_OP_SKZ      4'h1
`define SX_OP_MVSKZ    4'h2
`define SX_OP_BITSKZ   4'h3
`define SX_OP_TRDC     4'h4
`define SX_OP_TRDL     4'h5
`define SX_OP_XORA     4'h6
`define SX_OP_XMEM     4'h7
`define SX_OP_XORI     4'h8

// Register byte offsets on the bus.
`define SX_REG_ACCUM   8'h00
`define SX_REG_FLAGS   8'h04
`define SX_REG_TPTR    8'h08
`define SX_REG_THIGH   8'h0C
`define SX_REG_EXEC    8'h10

// Flag bit positions in the flags register.
`define SX_FLAG_C      0
`define SX_FLAG_AC     1
`define SX_FLAG_Z      2
`define SX_FLAG_OV     3
`define SX_FLAG_W      4

// Reset values.
`define SX_RST_BYTE    8'h00
`define SX_RST_FLAGS   4'h0
`define SX_RST_CNT     8'h00

`endif

// ---- design/sx_pkg.sv ----
// Types shared by the swap, skip, table read and XOR execution unit.
package sx_pkg;

   // Sequencer states, one-hot.
   typedef enum logic [2:0] {
      SX_ST_IDLE  = 3'b001,
      SX_ST_EXEC  = 3'b010,
      SX_ST_DUMMY = 3'b100
   } sx_state_e;

   // Byte carried through the unit.
   typedef logic [7:0] sx_byte_t;

endpackage

// ---- design/sx_exec_unit.sv ----
// Execution unit for nibble swap, zero skips, table reads and XOR instructions.
//
// Function
// - Swap nibbles of memory byte into accumulator; memory stays unchanged.
// - Skip-if-zero skips next instruction when whole memory byte is zero.
// - A taken skip discards the prefetch and adds one dummy cycle.
// - Move-and-skip copies memory into accumulator, skipping when value is zero.
// - Bit-test skip skips next instruction when selected memory bit is zero.
// - Current-page table read: low byte to memory, high byte to latch.
// - XOR accumulator with memory into accumulator, updating only zero flag.
// - XOR accumulator with memory back into memory, updating zero flag.
// - XOR accumulator with immediate into accumulator, updating zero flag.
//
// The implementer's own choices: the register offsets and the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
`include "sx_defs.svh"

module sx_exec_unit (
   input  wire logic                    clk_i,
   input  wire logic                    rst_i,
   // Instruction port from the decoder.
   input  wire logic                    instr_valid_i,
   input  wire logic [`SX_OP_W-1:0]     instr_op_i,
   input  wire logic [`SX_MEM_AW-1:0]   instr_addr_i,
   input  wire logic [2:0]              instr_bit_i,
   input  wire logic [`SX_DW-1:0]       instr_imm_i,
   input  wire logic [`SX_PAGE_W-1:0]   pc_page_i,
   output logic                         instr_ready_o,
   output logic                         skip_o,
   // Data memory port, asynchronous read, write on the clock edge.
   output logic [`SX_MEM_AW-1:0]        mem_addr_o,
   input  wire logic [`SX_DW-1:0]       mem_rdata_i,
   output logic                         mem_we_o,
   output logic [`SX_DW-1:0]            mem_wdata_o,
   // Program ROM port, asynchronous read.
   output logic [`SX_ROM_AW-1:0]        rom_addr_o,
   input  wire logic [`SX_ROM_DW-1:0]   rom_data_i,
   // Accumulator value for the rest of the core.
   output logic [`SX_DW-1:0]            accumulator_o,
   // Classic Wishbone slave.
   input  wire logic                    wb_cyc_i,
   input  wire logic                    wb_stb_i,
   input  wire logic                    wb_we_i,
   input  wire logic [7:0]              wb_adr_i,
   input  wire logic [3:0]              wb_sel_i,
   input  wire logic [31:0]             wb_dat_i,
   output logic [31:0]                  wb_dat_o,
   output logic                         wb_ack_o
);

   sx_pkg::sx_state_e            state_q;
   logic [`SX_OP_W-1:0]          op_q;
   logic [2:0]                   bit_q;
   logic [`SX_DW-1:0]            imm_q;
   logic [`SX_DW-1:0]            accumulator_q;
   logic [`SX_FLAG_W-1:0]        flags_q;
   logic [`SX_DW-1:0]            table_pointer_q;
   logic [`SX_HIGH_W-1:0]        table_high_latch_q;
   logic                         last_skip_q;
   logic [7:0]                   skip_cnt_q;

   logic                         accept;
   logic                         exec;
   logic                         bus_req;
   logic                         bus_wr;
   logic [`SX_DW-1:0]            mem_byte;
   logic [`SX_DW-1:0]            xor_mem;
   logic [`SX_DW-1:0]            xor_imm;
   logic                         skip_d;
   logic                         accum_wr;
   logic [`SX_DW-1:0]            accum_d;
   logic                         z_wr;
   logic                         z_d;
   logic                         mem_wr;
   logic [`SX_DW-1:0]            mem_d;
   logic                         high_wr;
   logic [`SX_PAGE_W-1:0]        page_sel;

   // Handshakes: an instruction is taken while the unit is idle and ready.
   assign accept   = instr_valid_i && instr_ready_o;
   assign exec     = (state_q == sx_pkg::SX_ST_EXEC);
   assign bus_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign bus_wr   = bus_req && wb_we_i && wb_sel_i[0];
   assign mem_byte = mem_rdata_i;
   assign xor_mem  = accumulator_q ^ mem_byte;
   assign xor_imm  = accumulator_q ^ imm_q;

   // Table page: the program counter page or the fixed last page.
   always_comb begin
      if (instr_op_i == `SX_OP_TRDL) begin
         page_sel = `SX_LAST_PAGE;
      end else begin
         page_sel = pc_page_i;
      end
   end

   // Result of the instruction held in the execute cycle.
   always_comb begin
      skip_d  = 1'b0;
      accum_wr = 1'b0;
      accum_d  = accumulator_q;
      z_wr    = 1'b0;
      z_d     = flags_q[`SX_FLAG_Z];
      mem_wr  = 1'b0;
      mem_d   = mem_byte;
      high_wr = 1'b0;
      unique case (op_q)
         `SX_OP_SWAP: begin
            accum_wr = 1'b1;
            accum_d  = {mem_byte[3:0], mem_byte[7:4]};
         end
         `SX_OP_SKZ: begin
            skip_d = (mem_byte == `SX_ZERO_BYTE);
         end
         `SX_OP_MVSKZ: begin
            accum_wr = 1'b1;
            accum_d  = mem_byte;
            skip_d = (mem_byte == `SX_ZERO_BYTE);
         end
         `SX_OP_BITSKZ: begin
            skip_d = !mem_byte[bit_q];
         end
         `SX_OP_TRDC, `SX_OP_TRDL: begin
            mem_wr  = 1'b1;
            mem_d   = rom_data_i[`SX_DW-1:0];
            high_wr = 1'b1;
         end
         `SX_OP_XORA: begin
            accum_wr = 1'b1;
            accum_d  = xor_mem;
            z_wr   = 1'b1;
            z_d    = (xor_mem == `SX_ZERO_BYTE);
         end
         `SX_OP_XMEM: begin
            mem_wr = 1'b1;
            mem_d  = xor_mem;
            z_wr   = 1'b1;
            z_d    = (xor_mem == `SX_ZERO_BYTE);
         end
         `SX_OP_XORI: begin
            accum_wr = 1'b1;
            accum_d  = xor_imm;
            z_wr   = 1'b1;
            z_d    = (xor_imm == `SX_ZERO_BYTE);
         end
         default: begin
            skip_d = 1'b0;
         end
      endcase
   end

   // Sequencer: idle, one execute cycle, and a dummy cycle for a taken skip.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q       <= sx_pkg::SX_ST_IDLE;
         instr_ready_o <= 1'b1;
         skip_o        <= 1'b0;
      end else begin
         unique case (state_q)
            sx_pkg::SX_ST_IDLE: begin
               skip_o <= 1'b0;
               if (accept) begin
                  state_q       <= sx_pkg::SX_ST_EXEC;
                  instr_ready_o <= 1'b0;
               end
            end
            sx_pkg::SX_ST_EXEC: begin
               if (skip_d) begin
                  state_q <= sx_pkg::SX_ST_DUMMY;
                  skip_o  <= 1'b1;
               end else begin
                  state_q       <= sx_pkg::SX_ST_IDLE;
                  instr_ready_o <= 1'b1;
               end
            end
            sx_pkg::SX_ST_DUMMY: begin
               state_q       <= sx_pkg::SX_ST_IDLE;
               instr_ready_o <= 1'b1;
               skip_o        <= 1'b0;
            end
            default: begin
               state_q       <= sx_pkg::SX_ST_IDLE;
               instr_ready_o <= 1'b1;
               skip_o        <= 1'b0;
            end
         endcase
      end
   end

   // Instruction fields are captured when the instruction is taken.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         op_q  <= `SX_OP_SWAP;
         bit_q <= 3'h0;
         imm_q <= `SX_RST_BYTE;
      end else if (accept) begin
         op_q  <= instr_op_i;
         bit_q <= instr_bit_i;
         imm_q <= instr_imm_i;
      end
   end

   // Memory and ROM addresses are registered when the instruction is taken, for use in the execute cycle.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mem_addr_o <= {`SX_MEM_AW{1'b0}};
         rom_addr_o <= {`SX_ROM_AW{1'b0}};
      end else if (accept) begin
         mem_addr_o <= instr_addr_i;
         rom_addr_o <= {page_sel, table_pointer_q};
      end
   end

   // Memory write strobe lasts one cycle, after the execute cycle.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mem_we_o    <= 1'b0;
         mem_wdata_o <= `SX_RST_BYTE;
      end else begin
         mem_we_o <= exec && mem_wr;
         if (exec && mem_wr) begin
            mem_wdata_o <= mem_d;
         end
      end
   end

   // Accumulator: execution wins over a bus write in the same cycle.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         accumulator_q <= `SX_RST_BYTE;
      end else if (exec && accum_wr) begin
         accumulator_q <= accum_d;
      end else if (bus_wr && wb_adr_i == `SX_REG_ACCUM) begin
         accumulator_q <= wb_dat_i[`SX_DW-1:0];
      end
   end

   // Mirror of the accumulator for the core.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         accumulator_o <= `SX_RST_BYTE;
      end else if (exec && accum_wr) begin
         accumulator_o <= accum_d;
      end else if (bus_wr && wb_adr_i == `SX_REG_ACCUM) begin
         accumulator_o <= wb_dat_i[`SX_DW-1:0];
      end
   end

   // Status flags: only XOR touches zero; others keep every flag.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flags_q <= `SX_RST_FLAGS;
      end else if (exec && z_wr) begin
         flags_q[`SX_FLAG_Z] <= z_d;
      end else if (bus_wr && wb_adr_i == `SX_REG_FLAGS) begin
         flags_q <= wb_dat_i[`SX_FLAG_W-1:0];
      end
   end

   // Table pointer is set by software and steers the ROM address.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         table_pointer_q <= `SX_RST_BYTE;
      end else if (bus_wr && wb_adr_i == `SX_REG_TPTR) begin
         table_pointer_q <= wb_dat_i[`SX_DW-1:0];
      end
   end

   // Table-high latch takes the upper ROM bits on a table read.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         table_high_latch_q <= {`SX_HIGH_W{1'b0}};
      end else if (exec && high_wr) begin
         table_high_latch_q <= rom_data_i[`SX_ROM_DW-1:`SX_DW];
      end
   end

   // Skip history: last outcome and a wrapping count of taken skips.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         last_skip_q <= 1'b0;
         skip_cnt_q  <= `SX_RST_CNT;
      end else if (exec) begin
         last_skip_q <= skip_d;
         if (skip_d) begin
            skip_cnt_q <= skip_cnt_q + 8'h01;
         end
      end
   end

   // Bus answer: one wait state, ack for one cycle, zero for unmapped words.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= bus_req;
         if (bus_req) begin
            unique case (wb_adr_i)
               `SX_REG_ACCUM: wb_dat_o <= {24'h00_0000, accumulator_q};
               `SX_REG_FLAGS: wb_dat_o <= {28'h000_0000, flags_q};
               `SX_REG_TPTR:  wb_dat_o <= {24'h00_0000, table_pointer_q};
               `SX_REG_THIGH: wb_dat_o <= {26'h000_0000, table_high_latch_q};
               `SX_REG_EXEC:  wb_dat_o <= {16'h0000, skip_cnt_q, 6'h00,
                                           last_skip_q, !instr_ready_o};
               default:       wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

endmodule
`default_nettype wire

// ---- sim/sx_exec_unit_checker.sv ----
// Concurrent checks on the ports of the execution unit.
`timescale 1ns/10ps
`default_nettype none
`include "sx_defs.svh"
module sx_exec_unit_checker (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        instr_valid_i,
   input wire logic [3:0]  instr_op_i,
   input wire logic [2:0]  instr_bit_i,
   input wire logic [7:0]  instr_imm_i,
   input wire logic [1:0]  pc_page_i,
   input wire logic        instr_ready_o,
   input wire logic        skip_o,
   input wire logic [7:0]  mem_rdata_i,
   input wire logic        mem_we_o,
   input wire logic [7:0]  mem_wdata_o,
   input wire logic [9:0]  rom_addr_o,
   input wire logic [13:0] rom_data_i,
   input wire logic [7:0]  accumulator_o
);
   logic       go;
   logic [2:0] bit_q;

   // An instruction is taken at this edge.
   assign go = instr_valid_i && instr_ready_o;

   // Keeps the bit index of the instruction in flight.
   always_ff @(posedge clk_i) if (go) bit_q <= instr_bit_i;

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // Results are checked two edges after the accept, the table address one edge after.
   property p_swap;
      go && instr_op_i == `SX_OP_SWAP |-> ##2 !mem_we_o
         && accumulator_o == {$past(mem_rdata_i[3:0]), $past(mem_rdata_i[7:4])};
   endproperty
   a_swap: assert property (p_swap) else $error("swap result wrong");
   property p_skip;
      skip_o |-> !instr_ready_o ##1 (instr_ready_o && !skip_o);
   endproperty
   a_skip: assert property (p_skip) else $error("skip length wrong");
   property p_skz;
      go && instr_op_i == `SX_OP_SKZ |-> ##2 !mem_we_o
         && skip_o == ($past(mem_rdata_i) == `SX_ZERO_BYTE);
   endproperty
   a_skz: assert property (p_skz) else $error("byte skip wrong");
   property p_mvskz;
      go && instr_op_i == `SX_OP_MVSKZ |-> ##2 accumulator_o == $past(mem_rdata_i)
         && skip_o == ($past(mem_rdata_i) == 8'h00);
   endproperty
   a_mvskz: assert property (p_mvskz) else $error("move skip wrong");
   property p_bitskz;
      go && instr_op_i == `SX_OP_BITSKZ |-> ##2 skip_o == !$past(mem_rdata_i[bit_q]);
   endproperty
   a_bitskz: assert property (p_bitskz) else $error("bit skip wrong");
   property p_table;
      go && (instr_op_i == `SX_OP_TRDC || instr_op_i == `SX_OP_TRDL) |=> rom_addr_o[9:8]
         == $past(instr_op_i == `SX_OP_TRDL ? `SX_LAST_PAGE : pc_page_i)
         ##1 (mem_we_o && mem_wdata_o == $past(rom_data_i[7:0]));
   endproperty
   a_table: assert property (p_table) else $error("table read wrong");
   property p_xora;
      go && instr_op_i == `SX_OP_XORA |-> ##2 !mem_we_o
         && accumulator_o == $past(accumulator_o ^ mem_rdata_i);
   endproperty
   a_xora: assert property (p_xora) else $error("xor to accumulator wrong");
   property p_xmem;
      go && instr_op_i == `SX_OP_XMEM |-> ##2 mem_we_o && accumulator_o == $past(accumulator_o)
         && mem_wdata_o == $past(accumulator_o ^ mem_rdata_i);
   endproperty
   a_xmem: assert property (p_xmem) else $error("xor to memory wrong");
   property p_xori;
      go && instr_op_i == `SX_OP_XORI |-> ##2
         accumulator_o == ($past(accumulator_o) ^ $past(instr_imm_i, 2));
   endproperty
   a_xori: assert property (p_xori) else $error("xor immediate wrong");
endmodule

bind sx_exec_unit sx_exec_unit_checker i_chk (.clk_i, .rst_i, .instr_valid_i, .instr_op_i,
   .instr_bit_i, .instr_imm_i, .pc_page_i, .instr_ready_o, .skip_o, .mem_rdata_i, .mem_we_o,
   .mem_wdata_o, .rom_addr_o, .rom_data_i, .accumulator_o);
`default_nettype wire

// ---- sim/sx_exec_unit_tb.sv ----
// Self-checking testbench for the execution unit.
`timescale 1ns/10ps
`default_nettype none
`include "sx_defs.svh"
module sx_exec_unit_tb;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        instr_valid_i = 1'b0;
   logic [3:0]  instr_op_i = 4'h0;
   logic [6:0]  instr_addr_i = 7'h00;
   logic [2:0]  instr_bit_i = 3'h0;
   logic [7:0]  instr_imm_i = 8'h00;
   logic [1:0]  pc_page_i = 2'h0;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        wb_we_i = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h00000000;
   logic        instr_ready_o, skip_o, mem_we_o, wb_ack_o;
   logic [6:0]  mem_addr_o;
   logic [7:0]  mem_rdata_i, mem_wdata_o, accumulator_o;
   logic [9:0]  rom_addr_o;
   logic [13:0] rom_data_i;
   logic [31:0] wb_dat_o, rd;
   logic [7:0]  mem [128];
   int          fails = 0;
   int          checks_done = 0;

   sx_exec_unit i_dut (.clk_i, .rst_i, .instr_valid_i, .instr_op_i, .instr_addr_i, .instr_bit_i,
      .instr_imm_i, .pc_page_i, .instr_ready_o, .skip_o, .mem_addr_o, .mem_rdata_i, .mem_we_o,
      .mem_wdata_o, .rom_addr_o, .rom_data_i, .accumulator_o, .wb_cyc_i, .wb_stb_i, .wb_we_i,
      .wb_adr_i, .wb_sel_i(4'hF), .wb_dat_i, .wb_dat_o, .wb_ack_o);

   // Clock, data memory with asynchronous read, and a ROM whose word encodes its address.
   always #4 clk_i = ~clk_i;
   always @(posedge clk_i) if (mem_we_o) mem[mem_addr_o] <= mem_wdata_o;
   assign mem_rdata_i = mem[mem_addr_o];
   assign rom_data_i  = {rom_addr_o[9:4], rom_addr_o[7:0] ^ 8'h5A};

   // Prints the counts and the verdict, then ends the run.
   task automatic conclude;
      $display("Checks %0d, mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // Counts a comparison and reports a mismatch.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // One classic Wishbone cycle, held until ack is sampled high.
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (n >= 20) begin
         chk(32'h0, 32'h1);
         conclude();
      end
   endtask

   // Reads a register and compares it.
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h00000000);
      chk(rd, e);
   endtask

   // Issues one instruction and checks its length and skip pulse.
   task automatic ex(input logic [3:0] o, input logic [6:0] a, input logic [2:0] b,
                     input logic [7:0] i, input logic s);
      int   n;
      logic sk;
      n = 0;
      sk = 1'b0;
      @(posedge clk_i);
      instr_valid_i <= 1'b1;
      instr_op_i    <= o;
      instr_addr_i  <= a;
      instr_bit_i   <= b;
      instr_imm_i   <= i;
      @(posedge clk_i);
      chk(instr_ready_o, 1'b1);
      instr_valid_i <= 1'b0;
      do begin
         @(posedge clk_i);
         n++;
         sk |= skip_o;
      end while (instr_ready_o !== 1'b1 && n < 20);
      chk(n, s ? 32'h3 : 32'h2);
      chk(sk, s);
      if (n >= 20) conclude();
      @(negedge clk_i);
   endtask

   // Reset values, an unmapped read and a write to the read-only latch.
   task automatic t_reset;
      for (int k = 0; k < 6; k++) rchk(8'(k * 4), 32'h00000000);
      wb(1'b1, 8'h0C, 32'h0000003F);
      rchk(8'h0C, 32'h00000000);
   endtask

   // Nibble swap into the accumulator with all flags set.
   task automatic t_swap;
      wb(1'b1, 8'h04, 32'h0000000F);
      mem[5] = 8'hA3;
      ex(`SX_OP_SWAP, 7'h05, 3'h0, 8'h00, 1'b0);
      rchk(8'h00, 32'h0000003A);
      chk(mem[5], 8'hA3);
   endtask

   // Byte, move and bit skips over zero and non-zero bytes.
   task automatic t_skip;
      logic [7:0] v [3] = '{8'h00, 8'h01, 8'h80};
      for (int k = 0; k < 3; k++) begin
         mem[7] = v[k];
         ex(`SX_OP_SKZ, 7'h07, 3'h0, 8'h00, v[k] == 8'h00);
         ex(`SX_OP_MVSKZ, 7'h07, 3'h0, 8'h00, v[k] == 8'h00);
         rchk(8'h00, {24'h0, v[k]});
         chk(mem[7], v[k]);
         ex(`SX_OP_BITSKZ, 7'h07, 3'h7, 8'h00, !v[k][7]);
         ex(`SX_OP_BITSKZ, 7'h07, 3'h0, 8'h00, !v[k][0]);
      end
      rchk(8'h10, 32'h00000602);
      rchk(8'h04, 32'h0000000F);
   endtask

   // Table reads from the current page and from the last page.
   task automatic t_table;
      wb(1'b1, 8'h08, 32'h00000096);
      pc_page_i <= 2'h1;
      ex(`SX_OP_TRDC, 7'h09, 3'h0, 8'h00, 1'b0);
      rchk(8'h0C, 32'h00000019);
      chk(mem[9], 8'hCC);
      ex(`SX_OP_TRDL, 7'h0A, 3'h0, 8'h00, 1'b0);
      rchk(8'h0C, 32'h00000039);
      chk(mem[10], 8'hCC);
      rchk(8'h04, 32'h0000000F);
   endtask

   // XOR forms with carry, half carry and overflow set; only zero may move.
   task automatic t_xor;
      wb(1'b1, 8'h04, 32'h0000000B);
      wb(1'b1, 8'h00, 32'h00000055);
      mem[3] = 8'h55;
      mem[4] = 8'h3D;
      ex(`SX_OP_XORA, 7'h03, 3'h0, 8'h00, 1'b0);
      rchk(8'h00, 32'h00000000);
      rchk(8'h04, 32'h0000000F);
      wb(1'b1, 8'h00, 32'h0000003C);
      ex(`SX_OP_XMEM, 7'h04, 3'h0, 8'h00, 1'b0);
      chk(mem[4], 8'h01);
      rchk(8'h04, 32'h0000000B);
      ex(`SX_OP_XORI, 7'h04, 3'h0, 8'h3C, 1'b0);
      rchk(8'h00, 32'h00000000);
      rchk(8'h04, 32'h0000000F);
   endtask

   // A reset in mid-run must bring every register back to its reset value.
   task automatic t_mid_reset;
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
   endtask

   // Reset for 16 cycles, then the scenarios in turn.
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_swap();
      t_skip();
      t_table();
      t_xor();
      t_mid_reset();
      conclude();
   end
endmodule
`default_nettype wire
